// *** eip_ctrl.sv ***
// external interrupt lines, pending flags, two level priority and call sequencing
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module eip_ctrl
    import eip_pkg::*;
(
    input  wire logic         clk_sys,   // system clock, 125 MHz
    input  wire logic         srst,      // synchronous reset, active high
    input  wire logic         ext_line_a,// external pin, asynchronous
    input  wire logic         ext_line_b,// external pin, asynchronous
    input  wire logic [1:0]   src_req,   // on-chip requests, same clock
    input  wire eip_core_in_t core_in,   // core instruction boundaries
    output eip_call_t         call_out,  // vectored call to the core
    output logic              call_busy, // core held while long_call runs
    input  wire logic         psel,      // apb select
    input  wire logic         penable,   // apb enable
    input  wire logic         pwrite,    // apb direction
    input  wire logic [7:0]   paddr,     // apb byte address
    input  wire logic [31:0]  pwdata,    // apb write data
    output logic [31:0]       prdata,    // apb read data
    output logic              pready,    // apb ready
    output logic              pslverr,   // apb error, unmapped address
    output logic              irq        // level interrupt, unmasked events
);
    // active level of a line given its polarity bit
    function automatic logic line_active(input logic pol, input logic val);
        line_active = pol ? val : ~val;
    endfunction

    // lowest set bit wins, the fixed order among equals
    function automatic logic [1:0] first_idx(input logic [3:0] v);
        first_idx = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
    endfunction

    // software registers
    logic [7:0]  en_reg;          // source enables and global enable
    logic [1:0]  trig_kind;       // ext_a/ext_b_trigger_kind, 1 = edge
    logic [1:0]  ext_pol;         // ext_a/ext_b_polarity, 1 = active high
    logic [3:0]  prio;            // priority_select bits, 1 = high
    logic [3:0]  istat;           // sticky events
    logic [3:0]  imask;           // event mask
    // service state
    eip_state_t  state;           // idle or calling
    logic [2:0]  cnt;             // long_call cycles left
    logic        in_hi;           // high level routine running
    logic        in_lo;           // low level routine running
    logic [1:0]  pend;            // ext_a/ext_b_pending
    logic [1:0]  edge_seen;       // edge detected this cycle
    logic [1:0]  act_now;         // line active, synchronised
    // winner latched at the detect cycle
    logic [1:0]  win_q;           // source being vectored
    logic        lvl_q;           // its priority

    // apb decode
    wire         acc_phase = psel & penable;
    wire         wr_hit    = acc_phase & pready & pwrite;
    wire         wr_en     = wr_hit & (paddr == EIP_OFF_ENABLE);
    wire         wr_tc     = wr_hit & (paddr == EIP_OFF_TCTRL);
    wire         wr_pol    = wr_hit & (paddr == EIP_OFF_POL);
    wire         wr_prio   = wr_hit & (paddr == EIP_OFF_PRIO);
    wire         wr_istat  = wr_hit & (paddr == EIP_OFF_ISTAT);
    wire         wr_imask  = wr_hit & (paddr == EIP_OFF_IMASK);
    wire         mapped    = (paddr == EIP_OFF_ENABLE) | (paddr == EIP_OFF_TCTRL)
                           | (paddr == EIP_OFF_POL)    | (paddr == EIP_OFF_PRIO)
                           | (paddr == EIP_OFF_STATUS) | (paddr == EIP_OFF_ISTAT)
                           | (paddr == EIP_OFF_IMASK);
    // software clears an edge pending flag by writing zero to it
    wire [1:0]   sw_pend_clr = {2{wr_tc}} & ~{pwdata[EIP_TC_B_PEND], pwdata[EIP_TC_A_PEND]};

    // arbitration, evaluated every cycle
    wire [3:0]   src_pend = {src_req, pend};
    wire [3:0]   gated    = src_pend & en_reg[3:0]
                          & {4{en_reg[EIP_EN_GLOBAL]}};
    // a high request needs no high routine running; a low one needs none at all
    wire [3:0]   eligible = gated & (prio & {4{~in_hi}}
                          | ~prio & {4{~in_hi & ~in_lo}});
    wire [3:0]   hi_set   = eligible & prio;
    wire         win_lvl  = |hi_set;
    wire [1:0]   win_idx  = win_lvl ? first_idx(hi_set) : first_idx(eligible);
    // calls start only at an ordinary instruction boundary, never at the
    // return itself, so one instruction always follows a return first
    // a return flagged with a boundary in one cycle still never starts a call
    wire         take     = (state == EIP_IDLE) & (|eligible)
                          & core_in.insn_done & ~core_in.stall
                          & ~core_in.return_from_interrupt_done;
    wire         fire     = (state == EIP_CALL) & (cnt == EIP_DETECT_CYC)
                          & ~core_in.stall;
    wire [3:0]   ev_set   = {edge_seen[1], edge_seen[0],
                             take & win_lvl & in_lo, fire};
    wire [3:0]   next_istat = ev_set | (istat & ~({4{wr_istat}} & pwdata[3:0]));
    // mask as it stands after this edge, so irq never lags a mask write
    // by one cycle and tracks the unmasked status exactly
    wire [3:0]   next_imask = wr_imask ? pwdata[3:0] : imask;
    wire [31:0]  rd_mux   =
        (paddr == EIP_OFF_ENABLE) ? {24'h000000, en_reg} :
        (paddr == EIP_OFF_TCTRL)  ? {28'h0000000, pend[1], trig_kind[1],
                                     pend[0], trig_kind[0]} :
        (paddr == EIP_OFF_POL)    ? {30'h0, ext_pol} :
        (paddr == EIP_OFF_PRIO)   ? {28'h0000000, prio} :
        (paddr == EIP_OFF_STATUS) ? {26'h0, call_out.vec, call_busy,
                                     call_out.level, in_hi, in_lo} :
        (paddr == EIP_OFF_ISTAT)  ? {28'h0000000, istat} :
        (paddr == EIP_OFF_IMASK)  ? {28'h0000000, imask} : 32'h00000000;

    // per line: synchroniser, edge detect, pending flag
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_line
            logic s1;          // first stage, read only by s2
            logic s2;          // synchronised level
            logic s3;          // previous level for edge detect
            wire  pin     = (gi == 0) ? ext_line_a : ext_line_b;
            wire  act     = line_active(ext_pol[gi], s2);
            wire  act_q   = line_active(ext_pol[gi], s3);
            wire  edg     = act & ~act_q;
            wire  vec_clr = fire & (win_q == 2'(gi));
            // edge set beats any clear arriving in the same cycle
            wire  next_pend = trig_kind[gi] ? (edg | (pend[gi] & ~vec_clr
                                               & ~sw_pend_clr[gi]))
                                            : act;
            assign edge_seen[gi] = edg & trig_kind[gi];
            assign act_now[gi]   = act;
            // own pin sampled directly, nothing driven back onto it
            always_ff @(posedge clk_sys) begin
                s1 <= pin;
                s2 <= s1;
                s3 <= s2;
            end
            // pending flag register
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    pend[gi] <= 1'b0;
                end else begin
                    pend[gi] <= next_pend;
                end
            end
        end
    endgenerate

    // call sequencer: one detect cycle then five call cycles
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state <= EIP_IDLE;
            cnt   <= 3'h0;
            win_q <= 2'h0;
            lvl_q <= 1'b0;
        end else begin
            case (state)
                EIP_IDLE: begin
                    if (take) begin
                        state <= EIP_CALL;
                        cnt   <= EIP_CALL_CYC;
                        win_q <= win_idx;
                        lvl_q <= win_lvl;
                    end
                end
                EIP_CALL: begin
                    // a stall freezes the count, stretching the response
                    if (!core_in.stall) begin
                        cnt <= cnt - EIP_DETECT_CYC;
                    end
                    if (fire) begin
                        state <= EIP_IDLE;
                    end
                end
                default: begin
                    state <= EIP_IDLE;
                end
            endcase
        end
    end

    // levels in service: set on the call, innermost released on return
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            in_hi <= 1'b0;
            in_lo <= 1'b0;
        end else if (fire) begin
            in_hi <= in_hi | lvl_q;
            in_lo <= in_lo | ~lvl_q;
        end else if (core_in.return_from_interrupt_done) begin
            in_hi <= 1'b0;
            in_lo <= in_hi & in_lo;
        end
    end

    // call outputs to the core
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            call_out  <= '0;
            call_busy <= 1'b0;
        end else begin
            call_out.call <= fire;
            call_busy     <= take | ((state == EIP_CALL) & ~fire);
            if (take) begin
                call_out.vec   <= win_idx;
                call_out.level <= win_lvl;
            end
        end
    end

    // software registers, written at the apb access edge
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            en_reg    <= EIP_RST_ENABLE;
            trig_kind <= EIP_RST_KIND;
            ext_pol   <= EIP_RST_POL;
            prio      <= EIP_RST_PRIO;
            imask     <= EIP_RST_MASK;
        end else begin
            if (wr_en)    en_reg    <= pwdata[7:0];
            if (wr_tc)    trig_kind <= {pwdata[EIP_TC_B_KIND], pwdata[EIP_TC_A_KIND]};
            if (wr_pol)   ext_pol   <= pwdata[1:0];
            if (wr_prio)  prio      <= pwdata[3:0];
            if (wr_imask) imask     <= pwdata[3:0];
        end
    end

    // sticky events and interrupt line; a new event wins over its clear
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            istat <= 4'h0;
            irq   <= 1'b0;
        end else begin
            istat <= next_istat;
            irq   <= |(next_istat & next_imask);
        end
    end

    // apb slave: one wait state so read data comes from a flop
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= acc_phase & ~pready;
            if (acc_phase & ~pready) begin
                prdata  <= pwrite ? 32'h00000000 : rd_mux;
                pslverr <= ~mapped;
            end
        end
    end

    // checks
    a_min_response: assert property (@(posedge clk_sys) disable iff (srst)
        (take ##1 !core_in.stall [*5]) |=> call_out.call)
        else $error("call not finished six cycles after detect");
    a_stall_hold: assert property (@(posedge clk_sys) disable iff (srst)
        (state == EIP_CALL && core_in.stall) |=> (cnt == $past(cnt) && !call_out.call))
        else $error("call advanced during a stall");
    a_hi_no_preempt: assert property (@(posedge clk_sys) disable iff (srst)
        take |-> !in_hi)
        else $error("call taken while high routine runs");
    a_lo_blocked: assert property (@(posedge clk_sys) disable iff (srst)
        (take && !win_lvl) |-> !in_lo)
        else $error("low call taken while low routine runs");
    a_prio_first: assert property (@(posedge clk_sys) disable iff (srst)
        (take && |(gated & prio) && !in_hi) |-> prio[win_idx])
        else $error("low source won over high");
    a_boundary_only: assert property (@(posedge clk_sys) disable iff (srst)
        core_in.return_from_interrupt_done |-> !take)
        else $error("call taken at the return boundary");
    a_enable_gate: assert property (@(posedge clk_sys) disable iff (srst)
        take |-> (en_reg[EIP_EN_GLOBAL] && en_reg[win_idx]))
        else $error("disabled source vectored");
    a_level_follow: assert property (@(posedge clk_sys) disable iff (srst)
        (!trig_kind[0] && !$past(srst)) |=> (pend[0] == $past(act_now[0]) || trig_kind[0]))
        else $error("level pending does not follow line a");
    a_edge_clear: assert property (@(posedge clk_sys) disable iff (srst)
        (fire && !win_q[1] && trig_kind[win_q[0]] && !edge_seen[win_q[0]])
        |=> !pend[win_q[0]])
        else $error("edge pending not cleared on vector");
    a_busy_span: assert property (@(posedge clk_sys) disable iff (srst)
        (take ##1 !core_in.stall [*5]) |-> call_busy ##1 !call_busy)
        else $error("call busy window wrong");
    a_release_lvl: assert property (@(posedge clk_sys) disable iff (srst)
        (core_in.return_from_interrupt_done && !fire && in_hi) |=> !in_hi)
        else $error("high level not released on return");
    a_irq_level: assert property (@(posedge clk_sys) disable iff (srst)
        ##1 (irq == |(istat & imask)))
        else $error("irq differs from unmasked events");
    a_apb_wait: assert property (@(posedge clk_sys) disable iff (srst)
        (acc_phase && !pready) |=> pready)
        else $error("apb answer late");
endmodule
`default_nettype wire

// *** eip_pkg.sv ***
// constants and types shared by the external interrupt and priority block
package eip_pkg;
    // source count and indices, fixed arbitration order: lowest index first
    localparam int unsigned EIP_NSRC      = 4;
    localparam logic [1:0]  EIP_SRC_A     = 2'h0;    // ext_line_a
    localparam logic [1:0]  EIP_SRC_B     = 2'h1;    // ext_line_b
    // register byte offsets on the apb bus
    localparam logic [7:0]  EIP_OFF_ENABLE = 8'h00;  // source and global enables
    localparam logic [7:0]  EIP_OFF_TCTRL  = 8'h04;  // timer_ctrl_reg view
    localparam logic [7:0]  EIP_OFF_POL    = 8'h08;  // polarity bits
    localparam logic [7:0]  EIP_OFF_PRIO   = 8'h0C;  // priority select bits
    localparam logic [7:0]  EIP_OFF_STATUS = 8'h10;  // service state, read only
    localparam logic [7:0]  EIP_OFF_ISTAT  = 8'h14;  // sticky events, write one clears
    localparam logic [7:0]  EIP_OFF_IMASK  = 8'h18;  // event mask
    // field positions
    localparam int unsigned EIP_EN_GLOBAL  = 7;      // global enable in enable reg
    localparam int unsigned EIP_TC_A_KIND  = 0;      // ext_a_trigger_kind
    localparam int unsigned EIP_TC_A_PEND  = 1;      // ext_a_pending
    localparam int unsigned EIP_TC_B_KIND  = 2;      // ext_b_trigger_kind
    localparam int unsigned EIP_TC_B_PEND  = 3;      // ext_b_pending
    localparam int unsigned EIP_EV_CALL    = 0;      // a vectored call completed
    localparam int unsigned EIP_EV_PREEMPT = 1;      // high level preempted low
    localparam int unsigned EIP_EV_EDGE_A  = 2;      // edge seen on line a
    localparam int unsigned EIP_EV_EDGE_B  = 3;      // edge seen on line b
    // reset values
    localparam logic [7:0]  EIP_RST_ENABLE = 8'h00;
    localparam logic [1:0]  EIP_RST_KIND   = 2'h0;   // level sensitive
    localparam logic [1:0]  EIP_RST_POL    = 2'h0;   // active low
    localparam logic [3:0]  EIP_RST_PRIO   = 4'h0;   // all low priority
    localparam logic [3:0]  EIP_RST_MASK   = 4'h0;
    // timing counts in system clock cycles
    localparam logic [2:0]  EIP_DETECT_CYC = 3'h1;   // detect cycle
    localparam logic [2:0]  EIP_CALL_CYC   = 3'h5;   // long_call duration
    // core side handshake
    typedef struct packed {
        logic insn_done;   // pulse: an ordinary instruction just completed
        logic return_from_interrupt_done;   // pulse: return_from_interrupt just completed
        logic stall;       // level: core stalled (flash or xdata_move fifo)
    } eip_core_in_t;
    typedef struct packed {
        logic       call;  // pulse: long_call to the service routine finished
        logic       level; // priority of the vectored source, 1 = high
        logic [1:0] vec;   // vectored source index
    } eip_call_t;
    typedef enum logic [1:0] {EIP_IDLE, EIP_CALL} eip_state_t;
endpackage

// *** eip_core_model.sv ***
// processor core model: instruction boundaries, returns, stalls, call timing
`timescale 1ns/100ps
`default_nettype none
module eip_core_model
    import eip_pkg::*;
(
    input  wire logic      clk_sys,   // system clock
    input  wire logic      srst,      // sync reset, active high
    input  wire logic      stall_req, // bench asks for a core stall
    input  wire eip_call_t call_out,  // vectored call from the block
    output eip_core_in_t   core_in,   // boundaries and stall to the block
    output logic [7:0]     lat,       // cycles from last boundary to call
    output logic [7:0]     n_call     // calls seen so far
);
    logic [7:0] since; // cycles since the last instruction boundary
    initial core_in = '0;
    initial since = 8'h00;
    // stall is registered, as a real core raises it off its own edge
    always @(posedge clk_sys) begin
        core_in.stall <= stall_req;
        since <= core_in.insn_done ? 8'h01 : since + 8'h01;
        if (srst) begin
            n_call <= 8'h00;
        end else if (call_out.call) begin
            n_call <= n_call + 8'h01;
            lat    <= since;
        end
    end
    // one ordinary instruction: a single-cycle boundary pulse
    task automatic insn();
        @(posedge clk_sys) core_in.insn_done <= 1'h1;
        @(posedge clk_sys) core_in.insn_done <= 1'h0;
    endtask
    // return from a service routine, never a call boundary by itself
    task automatic return_from_interrupt();
        @(posedge clk_sys) core_in.return_from_interrupt_done <= 1'h1;
        @(posedge clk_sys) core_in.return_from_interrupt_done <= 1'h0;
    endtask
endmodule
`default_nettype wire

// *** eip_ctrl_tb.sv ***
// self-checking bench for the external interrupt and priority block
`timescale 1ns/100ps
`default_nettype none
module eip_ctrl_tb;
    import eip_pkg::*;
    logic         clk_sys, srst, stall_req;  // clock, reset, stall ask
    logic         ext_line_a, ext_line_b;    // external pins
    logic [1:0]   src_req;                   // on-chip requests
    logic         psel, penable, pwrite;     // apb controls
    logic [7:0]   paddr;                     // apb address
    logic [31:0]  pwdata, prdata, rd;        // apb data, last read
    logic         pready, pslverr, irq, err; // answers
    eip_core_in_t core_in;                   // core boundaries
    eip_call_t    call_out;                  // vectored call
    logic         call_busy;                 // call in progress
    logic [7:0]   lat, n_call, base;         // model observations
    int           n_mismatch, compares, cyc; // counters
    logic [7:0]   offs [7] = '{EIP_OFF_ENABLE, EIP_OFF_TCTRL, EIP_OFF_POL,
        EIP_OFF_PRIO, EIP_OFF_STATUS, EIP_OFF_ISTAT, EIP_OFF_IMASK}; // all registers

    eip_ctrl uut (.clk_sys(clk_sys), .srst(srst), .ext_line_a(ext_line_a),
        .ext_line_b(ext_line_b), .src_req(src_req), .core_in(core_in),
        .call_out(call_out), .call_busy(call_busy), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));
    eip_core_model core (.clk_sys(clk_sys), .srst(srst), .stall_req(stall_req),
        .call_out(call_out), .core_in(core_in), .lat(lat), .n_call(n_call));

    // free-running 125 MHz clock
    initial begin
        clk_sys = 1'h0;
        forever #4 clk_sys = ~clk_sys;
    end
    // hang guard, well above the few hundred cycles the run needs
    initial cyc = 0;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic summarize();
        if (n_mismatch == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        // no limit of its own: the hang guard ends a dead bus
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'h1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    // waits for the next call pulse, the hang guard bounds it
    task automatic wait_call();
        while (n_call == base) begin
            @(posedge clk_sys);
        end
        base = n_call;
    endtask

    initial begin
        srst = 1'h1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ext_line_a, ext_line_b, src_req, stall_req} = 5'h18;
        {n_mismatch, compares, base} = '0;
        wait_cyc(20);
        srst <= 1'h0;
        // reset values, unmapped and read-only places
        foreach (offs[i]) rdchk(offs[i], 32'h0);
        wr(8'h1C, 32'hFF);
        chk(err, 1'h1);
        wr(EIP_OFF_STATUS, 32'hFF);
        rdchk(EIP_OFF_STATUS, 32'h0);
        // level mode follows the pins, both polarities
        @(posedge clk_sys) ext_line_a <= 1'h0;
        wait_cyc(5);
        rdchk(EIP_OFF_TCTRL, 32'h2);
        @(posedge clk_sys) ext_line_b <= 1'h0;
        wait_cyc(5);
        rdchk(EIP_OFF_TCTRL, 32'hA);
        @(posedge clk_sys) {ext_line_a, ext_line_b} <= 2'h3;
        wait_cyc(5);
        rdchk(EIP_OFF_TCTRL, 32'h0);
        wr(EIP_OFF_POL, 32'h3);
        wait_cyc(5);
        rdchk(EIP_OFF_TCTRL, 32'hA);
        // edge mode: a active high, b active low, both latched
        @(posedge clk_sys) ext_line_a <= 1'h0;
        wr(EIP_OFF_POL, 32'h1);
        wr(EIP_OFF_TCTRL, 32'h5);
        wr(EIP_OFF_ISTAT, 32'hF);
        rdchk(EIP_OFF_TCTRL, 32'h5);
        @(posedge clk_sys) {ext_line_a, ext_line_b} <= 2'h2;
        wait_cyc(2);
        {ext_line_a, ext_line_b} <= 2'h1;
        wait_cyc(5);
        rdchk(EIP_OFF_TCTRL, 32'hF);
        wr(EIP_OFF_IMASK, 32'h1);
        wr(EIP_OFF_ENABLE, 32'h01);
        core.insn();
        wait_cyc(10);
        chk(n_call, base);
        wr(EIP_OFF_ENABLE, 32'h81);
        core.insn();
        wait_cyc(1);
        chk(call_busy, 1'h1);
        wait_call();
        chk(call_busy, 1'h0);
        chk(lat, 8'h06);
        chk({call_out.level, call_out.vec}, 3'h0);
        rdchk(EIP_OFF_TCTRL, 32'hD);
        rdchk(EIP_OFF_ISTAT, 32'hD);
        chk(irq, 1'h1);
        wr(EIP_OFF_ISTAT, 32'hD);
        wait_cyc(2);
        chk(irq, 1'h0);
        wr(EIP_OFF_TCTRL, 32'h5);
        rdchk(EIP_OFF_TCTRL, 32'h5);
        core.return_from_interrupt();
        rdchk(EIP_OFF_STATUS, 32'h0);
        // high first, high never preempted, return plus one instruction
        wr(EIP_OFF_PRIO, 32'h8);
        wr(EIP_OFF_ENABLE, 32'h8C);
        @(posedge clk_sys) src_req <= 2'h3;
        core.insn();
        wait_call();
        chk({call_out.level, call_out.vec}, 3'h7);
        @(posedge clk_sys) src_req <= 2'h1;
        core.insn();
        wait_cyc(10);
        chk(n_call, base);
        core.return_from_interrupt();
        wait_cyc(10);
        chk(n_call, base);
        core.insn();
        wait_call();
        chk({lat, 1'h0, call_out.level, call_out.vec}, 12'h062);
        // low in service, high request preempts
        @(posedge clk_sys) src_req <= 2'h3;
        core.insn();
        wait_call();
        chk({call_out.level, call_out.vec}, 3'h7);
        rdchk(EIP_OFF_ISTAT, 32'h3);
        rdchk(EIP_OFF_STATUS, 32'h37);
        @(posedge clk_sys) src_req <= 2'h0;
        core.return_from_interrupt();
        core.return_from_interrupt();
        rdchk(EIP_OFF_STATUS, 32'h34);
        // equal priority: fixed order, lower index first
        wr(EIP_OFF_PRIO, 32'h0);
        @(posedge clk_sys) src_req <= 2'h3;
        core.insn();
        wait_call();
        chk({call_out.level, call_out.vec}, 3'h2);
        @(posedge clk_sys) src_req <= 2'h2;
        core.return_from_interrupt();
        // three stalled cycles inside the call stretch it by three
        core.insn();
        @(posedge clk_sys) stall_req <= 1'h1;
        wait_cyc(3);
        stall_req <= 1'h0;
        wait_call();
        chk({lat, 1'h0, call_out.vec}, 11'h04B);
        summarize();
    end
endmodule
`default_nettype wire
